// >>> hw/sds_pkg.sv
package sds_pkg;

	// Clock and timing
	localparam int unsigned CLK_MHZ          = 100;
	localparam int unsigned BLANK_NS         = 5500;
	localparam int unsigned BLANK_CYCLES     = (BLANK_NS * CLK_MHZ) / 1000;
	localparam int unsigned STEP_HOLDOFF_NS  = 10000;
	localparam int unsigned STEP_HOLDOFF_CYC = (STEP_HOLDOFF_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned BLANK_W          = 10;

	// APB register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PHASE  = 8'h08;

	// Control register fields
	localparam int unsigned CTRL_ENABLE_BIT = 0;
	localparam int unsigned CTRL_RESET_BIT  = 1;
	localparam logic [1:0]  CTRL_RESET_VAL  = 2'h2;

	// Status register fields
	localparam int unsigned ST_OVERCUR_BIT  = 0;
	localparam int unsigned ST_OVERHEAT_BIT = 1;
	localparam int unsigned ST_ENABLED_BIT  = 2;

	// Phase sequencer positions, Gray coded along the forward path
	typedef enum logic [1:0] {
		SDS_PH_A_BB  = 2'h0,
		SDS_PH_B_A   = 2'h1,
		SDS_PH_AB_B  = 2'h3,
		SDS_PH_BB_AB = 2'h2
	} sds_phase_t;

	// Four excitation outputs
	typedef struct packed {
		logic phase_a_drive;
		logic phase_a_bar_drive;
		logic phase_b_drive;
		logic phase_b_bar_drive;
	} sds_drive_t;

	localparam sds_drive_t DRIVE_OFF = 4'h0;

	// Decode a phase position into the four drive lines
	function automatic sds_drive_t phase_decode(input sds_phase_t ph);
		case (ph)
			SDS_PH_A_BB:  phase_decode = 4'h9;
			SDS_PH_B_A:   phase_decode = 4'hA;
			SDS_PH_AB_B:  phase_decode = 4'h6;
			SDS_PH_BB_AB: phase_decode = 4'h5;
			default:      phase_decode = 4'h9;
		endcase
	endfunction

endpackage

// >>> hw/sds_fault_latch.sv
`timescale 1ns/1ns
module sds_fault_latch
	import sds_pkg::*;
(
	input  wire logic pclk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic pwm_on,
	input  wire logic overcur_det,
	input  wire logic overheat_det,
	output logic      overcur_flag,
	output logic      overheat_flag,
	output logic      blanking
);

	logic [BLANK_W-1:0] blank_cnt;
	logic               pwm_on_d;

	// Blanking timer restarts on each PWM turn-on
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			blank_cnt <= '0;
			pwm_on_d  <= 1'b0;
		end else if (ce) begin
			pwm_on_d <= pwm_on;
			if (pwm_on && !pwm_on_d)
				blank_cnt <= BLANK_W'(BLANK_CYCLES);
			else if (blank_cnt != '0)
				blank_cnt <= blank_cnt - 1'b1;
		end
	end

	assign blanking = (blank_cnt != '0) || (pwm_on && !pwm_on_d);

	// Latched detections, cleared only by reset
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			overcur_flag  <= 1'b0;
			overheat_flag <= 1'b0;
		end else if (ce) begin
			if (overcur_det && !blanking)
				overcur_flag <= 1'b1;
			if (overheat_det)
				overheat_flag <= 1'b1;
		end
	end

	a_blank_masks_oc: assert property (@(posedge pclk) disable iff (!rst_n)
		(ce && overcur_det && blanking && !overcur_flag) |=> !overcur_flag)
		else $error("overcurrent latched while blanked");

	a_oc_blank_len: assert property (@(posedge pclk) disable iff (!rst_n)
		(ce && pwm_on && !pwm_on_d) |=> (blank_cnt == BLANK_W'(BLANK_CYCLES)))
		else $error("blank length wrong");

	a_oc_sets_flag: assert property (@(posedge pclk) disable iff (!rst_n)
		(ce && overcur_det && !blanking) |=> overcur_flag)
		else $error("overcurrent not latched");

	a_flags_sticky: assert property (@(posedge pclk) disable iff (!rst_n)
		(overcur_flag || overheat_flag) |=> (overcur_flag || overheat_flag))
		else $error("fault latch dropped");

endmodule

// >>> hw/sds_top.sv
`timescale 1ns/1ns
module sds_top
	import sds_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        system_reset_n_input,
	input  wire logic        enable,
	input  wire logic        step_clock,
	input  wire logic        direction_ccw,
	input  wire logic        pwm_on,
	input  wire logic        overcur_det,
	input  wire logic        overheat_det,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output sds_drive_t       drive,
	output logic             fault_o,
	output logic             fault_oe
);

	////////////////////////////////////////////////////////////////////////////
	// Reset combining

	logic       rst_n;
	logic       pin_rst_q;
	logic [1:0] ctrl;
	logic       sw_enable;
	logic       sw_reset;

	// Pin reset sampled synchronously; presetn stands for power-on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pin_rst_q <= 1'b0;
		else if (clk_en)
			pin_rst_q <= system_reset_n_input && !sw_reset;
	end

	assign rst_n = presetn && pin_rst_q;

	////////////////////////////////////////////////////////////////////////////
	// Enable gating of internal clock

	logic run_en;
	logic seq_ce;

	assign run_en = enable && sw_enable;
	assign seq_ce = clk_en && run_en;

	////////////////////////////////////////////////////////////////////////////
	// Phase sequencer

	sds_phase_t phase;
	sds_phase_t next_phase;
	logic       step_d;
	logic       overcur_flag;
	logic       overheat_flag;
	logic       blanking;
	logic       fault_latched;

	// Step forward or back on each step clock rising edge
	always_comb begin
		case (phase)
			SDS_PH_A_BB:  next_phase = direction_ccw ? SDS_PH_BB_AB : SDS_PH_B_A;
			SDS_PH_B_A:   next_phase = direction_ccw ? SDS_PH_A_BB  : SDS_PH_AB_B;
			SDS_PH_AB_B:  next_phase = direction_ccw ? SDS_PH_B_A   : SDS_PH_BB_AB;
			SDS_PH_BB_AB: next_phase = direction_ccw ? SDS_PH_AB_B  : SDS_PH_A_BB;
			default:      next_phase = SDS_PH_A_BB;
		endcase
	end

	// Sequencer state frozen while enable is low
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			phase  <= SDS_PH_A_BB;
			step_d <= 1'b0;
		end else if (seq_ce) begin
			step_d <= step_clock;
			if (step_clock && !step_d)
				phase <= next_phase;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Protection

	sds_fault_latch u_fault (
		.pclk          (pclk),
		.rst_n         (rst_n),
		.ce            (clk_en),
		.pwm_on        (pwm_on),
		.overcur_det   (overcur_det),
		.overheat_det  (overheat_det),
		.overcur_flag  (overcur_flag),
		.overheat_flag (overheat_flag),
		.blanking      (blanking)
	);

	assign fault_latched = overcur_flag || overheat_flag;

	// Drive outputs registered; off when disabled or faulted
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n)
			drive <= DRIVE_OFF;
		else if (clk_en) begin
			if (!run_en || fault_latched || (overcur_det && !blanking) || overheat_det)
				drive <= DRIVE_OFF;
			else
				drive <= phase_decode(phase);
		end
	end

	// Open-drain fault pin, low while a detection is latched
	assign fault_o  = 1'b0;
	assign fault_oe = fault_latched;

	////////////////////////////////////////////////////////////////////////////
	// APB slave

	logic apb_wr;
	logic apb_rd;
	logic addr_ok;

	assign pready  = 1'b1;
	assign addr_ok = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_PHASE);
	assign pslverr = psel && penable && !addr_ok;
	assign apb_wr  = psel && penable && pwrite && addr_ok;
	assign apb_rd  = psel && !penable && !pwrite;

	assign sw_enable = ctrl[CTRL_ENABLE_BIT];
	assign sw_reset  = ctrl[CTRL_RESET_BIT];

	// Control register; loads CTRL_RESET_VAL (reset bit set, enable clear) on power-on reset only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl <= CTRL_RESET_VAL;
		else if (clk_en && apb_wr && paddr == REG_CTRL)
			ctrl <= pwdata[1:0];
	end

	// Read data registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0;
		else if (clk_en && apb_rd) begin
			case (paddr)
				REG_CTRL:   prdata <= {30'h0, ctrl};
				REG_STATUS: prdata <= {29'h0, run_en, overheat_flag, overcur_flag};
				REG_PHASE:  prdata <= {28'h0, drive};
				default:    prdata <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_disable_off: assert property (@(posedge pclk) disable iff (!rst_n)
		(clk_en && !run_en) |=> (drive == DRIVE_OFF))
		else $error("drive on while disabled");

	a_phase_frozen: assert property (@(posedge pclk) disable iff (!rst_n)
		(!seq_ce) |=> $stable(phase))
		else $error("phase moved while frozen");

	a_fault_pin_low: assert property (@(posedge pclk) disable iff (!rst_n)
		(clk_en && (overheat_det || (overcur_det && !blanking))) |=> (fault_oe && !fault_o))
		else $error("fault pin not driven");

	a_fault_released: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(rst_n) |-> !fault_oe)
		else $error("fault pin driven after reset");

	a_fault_keeps_off: assert property (@(posedge pclk) disable iff (!rst_n)
		(fault_latched && clk_en) |=> (drive == DRIVE_OFF))
		else $error("drive on after fault");

	a_overheat_kills: assert property (@(posedge pclk) disable iff (!rst_n)
		(clk_en && overheat_det) |=> (drive == DRIVE_OFF))
		else $error("drive on during overheat");

	a_reset_phase: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(rst_n) |-> (phase == SDS_PH_A_BB))
		else $error("reset phase wrong");

	// Pin reset reaches the internal reset on the same edge that samples it
	a_pin_reset: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && !system_reset_n_input) |=> !rst_n)
		else $error("pin reset not taken");

	a_step_advance: assert property (@(posedge pclk) disable iff (!rst_n)
		(seq_ce && step_clock && !step_d) |=> (phase == $past(next_phase)))
		else $error("step not taken");

	// Main scenarios reached
	c_step: cover property (@(posedge pclk) seq_ce && step_clock && !step_d);
	c_fault: cover property (@(posedge pclk) $rose(fault_latched));
	c_disable: cover property (@(posedge pclk) $fell(run_en));
	c_blank: cover property (@(posedge pclk) blanking && overcur_det);
	c_release: cover property (@(posedge pclk) $rose(rst_n));

endmodule

// >>> verif/sds_host.sv
`timescale 1ns/1ns
// Host controller model: step pulses, reset pin pulses, holdoff
module sds_host
	import sds_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       step_req,
	input  wire logic       rst_req,
	input  wire logic [7:0] gap,
	output logic            step_clock,
	output logic            system_reset_n_input,
	output logic            busy
);
	logic [2:0]  st;
	logic [10:0] cnt;
	////////////////////////////////////////////////////////////////////////////
	// 0 idle, 1 pin low, 2 holdoff, 3 step high, 4 step low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= 3'h0;
			cnt <= 11'h0;
		end else if (cnt != 11'h0) begin
			cnt <= cnt - 11'h1;
		end else if (st == 3'h0) begin
			st <= rst_req ? 3'h1 : (step_req ? 3'h3 : 3'h0);
			cnt <= (rst_req || step_req) ? 11'h3 + 11'(gap) : 11'h0;
		end else begin
			st <= (st == 3'h1 || st == 3'h3) ? st + 3'h1 : 3'h0;
			cnt <= (st == 3'h1) ? 11'(STEP_HOLDOFF_CYC) :
				(st == 3'h3 ? 11'h3 + 11'(gap) : 11'h0);
		end
	end
	// Pin stays high unless a pulse is asked for
	assign system_reset_n_input = (st != 3'h1);
	assign step_clock = (st == 3'h3);
	assign busy = (st != 3'h0);
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ns
module tb;
	import sds_pkg::*;
	logic        pclk, presetn, enable, direction_ccw, pwm_on, overcur_det, overheat_det, ce;
	logic        psel, penable, pwrite, step_req, rst_req, step_clock, rst_pin_n, busy;
	logic        pready, pslverr, fault_o, fault_oe, err;
	logic [7:0]  paddr, gap;
	logic [31:0] pwdata, prdata, rd, seed;
	sds_drive_t  drive;
	int          fails, check_count, ph;
	int          tbl[4] = '{9, 10, 6, 5};
	// Open-drain fault wire with pull-up
	wire         fault_n = fault_oe ? fault_o : 1'b1;
	////////////////////////////////////////////////////////////////////////////
	sds_top uut (
		.pclk(pclk), .presetn(presetn), .clk_en(ce), .system_reset_n_input(rst_pin_n),
		.enable(enable), .step_clock(step_clock), .direction_ccw(direction_ccw),
		.pwm_on(pwm_on), .overcur_det(overcur_det), .overheat_det(overheat_det), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .drive(drive), .fault_o(fault_o), .fault_oe(fault_oe)
	);
	sds_host host_m (
		.pclk(pclk), .presetn(presetn), .step_req(step_req), .rst_req(rst_req), .gap(gap),
		.step_clock(step_clock), .system_reset_n_input(rst_pin_n), .busy(busy)
	);
	////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		results();
	end
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following setup is not assigned in the same step
		@(posedge pclk);
	endtask
	// Step (s=1) or reset pin pulse (s=0) through the host model
	task automatic host(input logic s);
		step_req <= s;
		rst_req <= !s;
		@(posedge pclk);
		step_req <= 1'b0;
		rst_req <= 1'b0;
		@(posedge pclk);
		while (busy === 1'b1) begin
			@(posedge pclk);
		end
		repeat (2) @(posedge pclk);
	endtask
	task automatic cph(input int e);
		apb(1'b0, REG_PHASE, 32'h0);
		chk("phase", rd, 32'(e));
		chk("drive", 32'(drive), 32'(e));
	endtask
	task automatic results();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence; enable held low through reset
	initial begin
		{presetn, psel, penable, pwrite, step_req, rst_req, enable} = '0;
		{direction_ccw, pwm_on, overcur_det, overheat_det} = '0;
		ce = 1'b1;
		paddr = '0;
		pwdata = '0;
		gap = '0;
		fails = 0;
		check_count = 0;
		ph = 0;
		seed = 32'h06BDD88C;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl_rst", rd, 32'(CTRL_RESET_VAL));
		apb(1'b1, 8'h0C, xs(seed));
		chk("slverr", 32'(err), 32'h1);
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmapped", rd, 32'h0);
		chk("fault_idle", 32'(fault_n), 32'h1);
		$display("test reset done");
		apb(1'b1, REG_CTRL, 32'h1);
		enable <= 1'b1;
		host(1'b0);
		cph(9);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status_run", rd, 32'h4);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			direction_ccw <= seed[0];
			gap <= 8'(i * 4);
			ph = (ph + (seed[0] ? 3 : 1)) % 4;
			host(1'b1);
			cph(tbl[ph]);
		end
		$display("test steps done");
		enable <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("drive_off", 32'(drive), 32'h0);
		direction_ccw <= ~direction_ccw;
		host(1'b1);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status_dis", rd, 32'h0);
		enable <= 1'b1;
		repeat (2) @(posedge pclk);
		cph(tbl[ph]);
		// Clock enable low freezes the sequencer through a whole step pulse
		ce <= 1'b0;
		host(1'b1);
		chk("ce_frozen", 32'(drive), 32'(tbl[ph]));
		ce <= 1'b1;
		repeat (2) @(posedge pclk);
		cph(tbl[ph]);
		$display("test enable done");
		pwm_on <= 1'b1;
		repeat (10) @(posedge pclk);
		overcur_det <= 1'b1;
		repeat (100) @(posedge pclk);
		overcur_det <= 1'b0;
		@(posedge pclk);
		chk("blanked", 32'(fault_n), 32'h1);
		cph(tbl[ph]);
		repeat (BLANK_CYCLES) @(posedge pclk);
		overcur_det <= 1'b1;
		repeat (2) @(posedge pclk);
		overcur_det <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("fault_oc", 32'(fault_n), 32'h0);
		host(1'b1);
		cph(0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status_oc", rd, 32'h5);
		host(1'b0);
		cph(9);
		chk("fault_clr", 32'(fault_n), 32'h1);
		$display("test overcurrent done");
		overheat_det <= 1'b1;
		@(posedge pclk);
		overheat_det <= 1'b0;
		repeat (2) @(posedge pclk);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status_oh", rd, 32'h6);
		chk("fault_oh", 32'(fault_n), 32'h0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl_por", rd, 32'(CTRL_RESET_VAL));
		chk("fault_por", 32'(fault_n), 32'h1);
		cph(0);
		apb(1'b1, REG_CTRL, 32'h1);
		repeat (2) @(posedge pclk);
		cph(9);
		$display("test overheat done");
		results();
	end
endmodule
